// file: logic/twc_cond.sv
// start, stop and clock-edge detection on the filtered bus lines
`timescale 1ns/100ps
module twc_cond
	import twc_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// filtered lines
	input  wire logic scl,
	input  wire logic sda,
	// detected conditions
	output logic      start_p,
	output logic      stop_p,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      busy
);
	logic scl_q, sda_q, busy_q, busy_d;

	assign start_p  = scl & scl_q & sda_q & ~sda;
	assign stop_p   = scl & scl_q & ~sda_q & sda;
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign busy     = busy_q;

	always_comb begin
		busy_d = busy_q;
		if (start_p)
			busy_d = 1'b1;
		else if (stop_p)
			busy_d = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_q  <= LINE_IDLE;
			sda_q  <= LINE_IDLE;
			busy_q <= 1'b0;
		end else begin
			scl_q  <= scl;
			sda_q  <= sda;
			busy_q <= busy_d;
		end
	end
endmodule : twc_cond

// file: logic/twc_filt.sv
// two-flop synchroniser and digital glitch filter for one bus line
`timescale 1ns/100ps
module twc_filt
	import twc_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// line
	input  wire logic pin,
	input  wire logic filt_on,
	output logic      clean
);
	logic [1:0]          sync_q, sync_d;
	logic [FILT_LEN-1:0] hist_q, hist_d;
	logic                clean_q, clean_d;

	always_comb begin
		sync_d  = {sync_q[0], pin};
		hist_d  = {hist_q[FILT_LEN-2:0], sync_q[1]};
		clean_d = clean_q;
		// filter off in sleep: the slow clock cannot be trusted to sample
		if (!filt_on)
			clean_d = sync_q[1];
		else if (&hist_q)
			clean_d = 1'b1;
		else if (~|hist_q)
			clean_d = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_q  <= {2{LINE_IDLE}};
			hist_q  <= {FILT_LEN{LINE_IDLE}};
			clean_q <= LINE_IDLE;
		end else begin
			sync_q  <= sync_d;
			hist_q  <= hist_d;
			clean_q <= clean_d;
		end
	end

	assign clean = clean_q;
endmodule : twc_filt

// file: logic/twc_pkg.sv
// constants, register map and state encodings of the two-wire controller
package twc_pkg;
	// timing
	localparam int          CLK_NS     = 10;
	localparam int          STD_BIT_NS = 10000;
	localparam int          FMP_BIT_NS = 1000;
	localparam logic [15:0] DIV_RST    = 16'(STD_BIT_NS / (2 * CLK_NS));
	localparam logic [15:0] DIV_MIN    = 16'(FMP_BIT_NS / (2 * CLK_NS));
	localparam int          FILT_LEN   = 3;
	localparam logic        LINE_IDLE  = 1'b1;

	// register byte offsets
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_ADDR = 6'h04;
	localparam logic [5:0] OFF_DIV  = 6'h08;
	localparam logic [5:0] OFF_CMD  = 6'h0c;
	localparam logic [5:0] OFF_TX   = 6'h10;
	localparam logic [5:0] OFF_RX   = 6'h14;
	localparam logic [5:0] OFF_STAT = 6'h18;
	localparam logic [5:0] OFF_IRQ  = 6'h1c;
	localparam logic [5:0] OFF_MASK = 6'h20;

	// control bits
	localparam int CTRL_SLV   = 0;
	localparam int CTRL_MST   = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_WAKE  = 3;
	localparam int CTRL_W     = 4;

	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP  = 1;
	localparam int CMD_WRITE = 2;
	localparam int CMD_READ  = 3;
	localparam int CMD_NACK  = 4;
	localparam int CMD_W     = 5;

	// event bits of the interrupt status and mask
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_BYTE  = 2;
	localparam int EV_ADDR  = 3;
	localparam int EV_ARB   = 4;
	localparam int EV_NACK  = 5;
	localparam int EV_W     = 6;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [6:0]        ADDR_RST = 7'h00;
	localparam logic [7:0]        TX_RST   = 8'hff;
	localparam logic [7:0]        RX_RST   = 8'h00;
	localparam logic [EV_W-1:0]   EV_RST   = 6'h00;
	localparam logic [3:0]        BYTE_BITS = 4'h8;

	typedef enum logic [3:0] {M_IDLE, M_RS1, M_RS2, M_S3, M_HOLD, M_LO, M_HI, M_P1, M_P2, M_P3} twc_mst_t;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_MACK} twc_slv_t;
endpackage : twc_pkg

// file: logic/twc_top.sv
// two-wire serial controller: master, slave, arbitration and Avalon-MM registers
`timescale 1ns/100ps
// Function
// RL1: slave enabled means the bus is always watched for a start condition; the slave ignores starts while its own master is active.
// RL2: master enabled can drive start and stop and start transfers itself.
// RL3: with both enabled, clock synchronisation and arbitration share the bus.
// RL4: master only, slave off: external starts raise no interrupt.
// RL5: incoming 7-bit address is compared with own address in hardware.
// RL6: a 7-bit address match can wake the device from low power.
// RL7: first byte after start is 7-bit address plus direction, 1 is read.
// RL8: the controlling master ends every transfer with a stop.
// RL9: a repeated start may replace stop and address another slave.
// RL10: glitch filter works in active modes only, off in sleep.
// RL11: bus bit rates up to 1 Mbps are supported.
// RL12: ten-bit addressing is left to software; hardware matches 7 bits.
// RL13: framing generated and bus events detected in hardware, data byte-wise.
// RL14: status is offered both as interrupts and as polled flags.
// RL15: each byte is followed by a ninth clock carrying acknowledge.
module twc_top
	import twc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// register bus
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// system
	output logic             irq,
	output logic             wake,
	// bus lines, open drain
	input  wire logic        scl_line,
	output logic             scl_val,
	output logic             scl_oe,
	input  wire logic        sda_line,
	output logic             sda_val,
	output logic             sda_oe
);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		for (int i = 0; i < 4; i++)
			r[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		return r;
	endfunction : merge

	logic scl_f, sda_f, start_p, stop_p, scl_rise, scl_fall, busy;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;

	twc_filt u_scl (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     (scl_line),
		.filt_on (~ctrl_q[CTRL_SLEEP]), // [RL10]
		.clean   (scl_f)
	);
	twc_filt u_sda (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     (sda_line),
		.filt_on (~ctrl_q[CTRL_SLEEP]), // [RL10]
		.clean   (sda_f)
	);
	twc_cond u_cond (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.scl      (scl_f),
		.sda      (sda_f),
		.start_p  (start_p),
		.stop_p   (stop_p),
		.scl_rise (scl_rise),
		.scl_fall (scl_fall),
		.busy     (busy)
	);

	////////////////////////////////////////////////////////////////
	// register file
	logic              acc_q, acc_d, wr_en;
	logic [31:0]       rdata_q, rdata_d, wm;
	logic [6:0]        own_q, own_d;
	logic [15:0]       div_q, div_d;
	logic [7:0]        tx_q, tx_d, rx_q, rx_d;
	logic [EV_W-1:0]   stat_q, stat_d, mask_q, mask_d, ev;
	logic [CMD_W-1:0]  cmd_go;
	logic              wake_q, wake_d;
	twc_mst_t          m_st_q;
	twc_slv_t          s_st_q;
	logic              m_active, m_ack_q, s_dir_q, m_rx_ev, s_rx_ev;
	logic [7:0]        m_sh_q, s_sh_q;

	assign avs_waitrequest = (avs_read | avs_write) & ~acc_q;
	assign wr_en           = avs_write & acc_q;
	assign avs_readdata    = rdata_q;
	assign cmd_go          = (wr_en && avs_address == OFF_CMD && avs_byteenable[0]) ?
	                         avs_writedata[CMD_W-1:0] : '0;
	assign m_active        = (m_st_q != M_IDLE);
	assign irq             = |(stat_q & mask_q); // [RL14]
	assign wake            = wake_q;

	always_comb begin
		acc_d   = (avs_read | avs_write) & ~acc_q;
		rdata_d = rdata_q;
		ctrl_d  = ctrl_q;
		own_d   = own_q;
		div_d   = div_q;
		tx_d    = tx_q;
		mask_d  = mask_q;
		wake_d  = wake_q;
		wm      = '0;
		if (avs_read && !acc_q) begin
			case (avs_address)
			OFF_CTRL: rdata_d = {28'h0000000, ctrl_q};
			OFF_ADDR: rdata_d = {25'h0000000, own_q};
			OFF_DIV:  rdata_d = {16'h0000, div_q};
			OFF_TX:   rdata_d = {24'h000000, tx_q};
			OFF_RX:   rdata_d = {24'h000000, rx_q};
			OFF_STAT: rdata_d = {27'h0000000, m_ack_q, s_dir_q, s_st_q != S_IDLE, m_active, busy}; // [RL14]
			OFF_IRQ:  rdata_d = {26'h0000000, stat_q};
			OFF_MASK: rdata_d = {26'h0000000, mask_q};
			default:  rdata_d = 32'h00000000;
			endcase
		end
		if (wr_en) begin
			case (avs_address)
			OFF_CTRL: begin
				wm     = merge({28'h0000000, ctrl_q}, avs_writedata, avs_byteenable);
				ctrl_d = wm[CTRL_W-1:0];
			end
			OFF_ADDR: begin
				wm    = merge({25'h0000000, own_q}, avs_writedata, avs_byteenable);
				own_d = wm[6:0];
			end
			OFF_DIV: begin
				wm    = merge({16'h0000, div_q}, avs_writedata, avs_byteenable);
				// half periods shorter than the 1 Mbps one are clamped
				div_d = (wm[15:0] < DIV_MIN) ? DIV_MIN : wm[15:0]; // [RL11]
			end
			OFF_TX: begin
				wm   = merge({24'h000000, tx_q}, avs_writedata, avs_byteenable);
				tx_d = wm[7:0];
			end
			OFF_MASK: begin
				wm     = merge({26'h0000000, mask_q}, avs_writedata, avs_byteenable);
				mask_d = wm[EV_W-1:0];
			end
			default: wm = '0;
			endcase
		end
		// set wins over the write-one clear
		stat_d = stat_q;
		if (wr_en && avs_address == OFF_IRQ && avs_byteenable[0])
			stat_d = stat_q & ~avs_writedata[EV_W-1:0];
		stat_d = stat_d | ev;
		rx_d = m_rx_ev ? m_sh_q : (s_rx_ev ? s_sh_q : rx_q);
		if (ev[EV_ADDR] && ctrl_q[CTRL_SLEEP] && ctrl_q[CTRL_WAKE])
			wake_d = 1'b1; // [RL6]
		else if (!ctrl_d[CTRL_SLEEP])
			wake_d = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_q   <= 1'b0;
			rdata_q <= 32'h00000000;
			ctrl_q  <= CTRL_RST;
			own_q   <= ADDR_RST;
			div_q   <= DIV_RST;
			tx_q    <= TX_RST;
			rx_q    <= RX_RST;
			stat_q  <= EV_RST;
			mask_q  <= EV_RST;
			wake_q  <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			rdata_q <= rdata_d;
			ctrl_q  <= ctrl_d;
			own_q   <= own_d;
			div_q   <= div_d;
			tx_q    <= tx_d;
			rx_q    <= rx_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			wake_q  <= wake_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// master engine
	twc_mst_t    m_st_d;
	logic [15:0] m_cnt_q, m_cnt_d;
	logic [3:0]  m_bit_q, m_bit_d;
	logic [7:0]  m_sh_d;
	logic        m_wr_q, m_wr_d, m_nack_q, m_nack_d, m_ack_d;
	logic        m_scl_q, m_scl_d, m_sda_q, m_sda_d, hi_q, hi_d;
	logic        done, mid, end_hi, bit_out, lost;
	logic        m_byte_ev, m_arb_ev, m_nack_ev;

	assign done    = (m_cnt_q >= div_q);
	assign mid     = (m_cnt_q == {1'b0, div_q[15:1]});
	assign end_hi  = (scl_f & done) | (~scl_f & hi_q); // [RL3]
	assign bit_out = (m_bit_q < BYTE_BITS) ? m_sh_q[7] : (m_wr_q | m_nack_q); // [RL15]
	// driving a one while the line reads zero means another master won
	assign lost    = scl_f & m_wr_q & (m_bit_q < BYTE_BITS) & ~m_sda_q & ~sda_f; // [RL3]

	always_comb begin
		m_st_d    = m_st_q;
		m_bit_d   = m_bit_q;
		m_sh_d    = m_sh_q;
		m_wr_d    = m_wr_q;
		m_nack_d  = m_nack_q;
		m_ack_d   = m_ack_q;
		m_scl_d   = m_scl_q;
		m_sda_d   = m_sda_q;
		hi_d      = hi_q;
		m_byte_ev = 1'b0;
		m_arb_ev  = 1'b0;
		m_nack_ev = 1'b0;
		m_rx_ev   = 1'b0;
		case (m_st_q)
		M_IDLE: begin
			m_scl_d = 1'b0;
			m_sda_d = 1'b0;
			if (cmd_go[CMD_START] && ctrl_q[CTRL_MST]) begin // [RL2]
				if (busy)
					m_arb_ev = 1'b1; // [RL3]
				else
					m_st_d = M_RS2;
			end
		end
		M_HOLD: begin
			m_scl_d = 1'b1;
			if (cmd_go[CMD_START])
				m_st_d = M_RS1; // [RL9]
			else if (cmd_go[CMD_STOP])
				m_st_d = M_P1; // [RL2]
			else if (cmd_go[CMD_WRITE] || cmd_go[CMD_READ]) begin // [RL13]
				m_st_d   = M_LO;
				m_bit_d  = 4'h0;
				m_wr_d   = cmd_go[CMD_WRITE];
				m_nack_d = cmd_go[CMD_NACK];
				m_sh_d   = cmd_go[CMD_WRITE] ? tx_q : TX_RST;
			end
		end
		M_RS1: begin
			if (mid)
				m_sda_d = 1'b0;
			if (done)
				m_st_d = M_RS2;
		end
		M_RS2: begin
			m_scl_d = 1'b0;
			if (scl_f && !sda_f) begin
				m_arb_ev = 1'b1; // [RL3]
				m_st_d   = M_IDLE;
			end else if (scl_f && done) begin
				m_sda_d = 1'b1; // [RL2]
				m_st_d  = M_S3;
			end
		end
		M_S3: begin
			if (done) begin
				m_scl_d = 1'b1;
				m_st_d  = M_HOLD;
			end
		end
		M_LO: begin
			m_scl_d = 1'b1;
			// data changes mid low phase, never next to a clock edge
			if (mid)
				m_sda_d = ~bit_out;
			if (done)
				m_st_d = M_HI;
		end
		M_HI: begin
			m_scl_d = 1'b0;
			if (scl_f)
				hi_d = 1'b1;
			if (lost) begin
				m_arb_ev = 1'b1; // [RL3]
				m_sda_d  = 1'b0;
				hi_d     = 1'b0;
				m_st_d   = M_IDLE;
			end else if (end_hi) begin
				hi_d    = 1'b0;
				m_scl_d = 1'b1;
				if (m_bit_q < BYTE_BITS) begin
					m_sh_d  = {m_sh_q[6:0], sda_f};
					m_bit_d = m_bit_q + 4'h1;
					m_st_d  = M_LO;
				end else begin
					m_byte_ev = 1'b1;
					m_ack_d   = sda_f; // [RL15]
					m_nack_ev = m_wr_q & sda_f;
					m_rx_ev   = ~m_wr_q;
					m_st_d    = M_HOLD;
				end
			end
		end
		M_P1: begin
			m_scl_d = 1'b1;
			if (mid)
				m_sda_d = 1'b1;
			if (done) begin
				m_scl_d = 1'b0;
				m_st_d  = M_P2;
			end
		end
		M_P2: begin
			if (scl_f && done) begin
				m_sda_d = 1'b0; // [RL8]
				m_st_d  = M_P3;
			end
		end
		M_P3: begin
			if (done)
				m_st_d = M_IDLE;
		end
		default: m_st_d = M_IDLE;
		endcase
		// phase timer waits for the line to rise when others stretch it
		if (m_st_d != m_st_q)
			m_cnt_d = 16'h0000;
		else if ((m_st_q == M_HI || m_st_q == M_RS2 || m_st_q == M_P2) && !scl_f)
			m_cnt_d = 16'h0000; // [RL3]
		else
			m_cnt_d = (m_cnt_q == 16'hffff) ? m_cnt_q : m_cnt_q + 16'h0001;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			m_st_q   <= M_IDLE;
			m_cnt_q  <= 16'h0000;
			m_bit_q  <= 4'h0;
			m_sh_q   <= TX_RST;
			m_wr_q   <= 1'b0;
			m_nack_q <= 1'b0;
			m_ack_q  <= 1'b0;
			m_scl_q  <= 1'b0;
			m_sda_q  <= 1'b0;
			hi_q     <= 1'b0;
		end else begin
			m_st_q   <= m_st_d;
			m_cnt_q  <= m_cnt_d;
			m_bit_q  <= m_bit_d;
			m_sh_q   <= m_sh_d;
			m_wr_q   <= m_wr_d;
			m_nack_q <= m_nack_d;
			m_ack_q  <= m_ack_d;
			m_scl_q  <= m_scl_d;
			m_sda_q  <= m_sda_d;
			hi_q     <= hi_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// slave engine; no clock stretching, so tx data must be ready in time
	twc_slv_t   s_st_d;
	logic [3:0] s_cnt_q, s_cnt_d;
	logic [7:0] s_sh_d;
	logic       s_dir_d, s_oe_q, s_oe_d, s_addr_ev, s_byte_ev;

	always_comb begin
		s_st_d    = s_st_q;
		s_cnt_d   = s_cnt_q;
		s_sh_d    = s_sh_q;
		s_dir_d   = s_dir_q;
		s_oe_d    = s_oe_q;
		s_addr_ev = 1'b0;
		s_byte_ev = 1'b0;
		s_rx_ev   = 1'b0;
		if (!ctrl_q[CTRL_SLV] || m_active || stop_p) begin
			s_st_d = S_IDLE;
			s_oe_d = 1'b0;
		end else if (start_p) begin // [RL1]
			s_st_d  = S_ADDR;
			s_cnt_d = 4'h0;
			s_oe_d  = 1'b0;
		end else begin
			case (s_st_q)
			S_ADDR, S_RX: begin
				if (scl_rise) begin
					s_sh_d  = {s_sh_q[6:0], sda_f};
					s_cnt_d = s_cnt_q + 4'h1;
				end
				if (scl_fall && s_cnt_q == BYTE_BITS) begin
					if (s_st_q == S_RX) begin
						s_rx_ev   = 1'b1; // [RL13]
						s_byte_ev = 1'b1;
						s_oe_d    = 1'b1; // [RL15]
						s_st_d    = S_ACK;
					end else if (s_sh_q[7:1] == own_q) begin // [RL5] [RL12]
						s_addr_ev = 1'b1;
						s_dir_d   = s_sh_q[0]; // [RL7]
						s_oe_d    = 1'b1; // [RL15]
						s_st_d    = S_ACK;
					end else begin
						s_st_d = S_IDLE;
					end
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					s_cnt_d = 4'h0;
					if (s_dir_q) begin
						s_sh_d = tx_q;
						s_oe_d = ~tx_q[7];
						s_st_d = S_TX;
					end else begin
						s_oe_d = 1'b0;
						s_st_d = S_RX;
					end
				end
			end
			S_TX: begin
				if (scl_rise)
					s_cnt_d = s_cnt_q + 4'h1;
				if (scl_fall) begin
					if (s_cnt_q == BYTE_BITS) begin
						s_oe_d = 1'b0;
						s_st_d = S_MACK;
					end else begin
						s_sh_d = {s_sh_q[6:0], 1'b0};
						s_oe_d = ~s_sh_q[6];
					end
				end
			end
			S_MACK: begin
				if (scl_rise) begin
					s_byte_ev = 1'b1;
					s_cnt_d   = 4'h0;
					if (sda_f)
						s_st_d = S_IDLE; // [RL15]
				end else if (scl_fall) begin
					s_sh_d = tx_q;
					s_oe_d = ~tx_q[7];
					s_st_d = S_TX;
				end
			end
			default: s_st_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_st_q  <= S_IDLE;
			s_cnt_q <= 4'h0;
			s_sh_q  <= RX_RST;
			s_dir_q <= 1'b0;
			s_oe_q  <= 1'b0;
		end else begin
			s_st_q  <= s_st_d;
			s_cnt_q <= s_cnt_d;
			s_sh_q  <= s_sh_d;
			s_dir_q <= s_dir_d;
			s_oe_q  <= s_oe_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// events and pins
	always_comb begin
		ev           = '0;
		ev[EV_START] = start_p & ctrl_q[CTRL_SLV] & ~m_active; // [RL4]
		ev[EV_STOP]  = stop_p;
		ev[EV_BYTE]  = m_byte_ev | s_byte_ev;
		ev[EV_ADDR]  = s_addr_ev; // [RL6]
		ev[EV_ARB]   = m_arb_ev;
		ev[EV_NACK]  = m_nack_ev;
	end

	assign scl_val = 1'b0;
	assign sda_val = 1'b0;
	assign scl_oe  = m_scl_q;
	assign sda_oe  = m_sda_q | s_oe_q;
endmodule : twc_top

// file: tb/twc_bus_model.sv
// far-side party on the two-wire bus: external master and acknowledging slave
`timescale 1ns/100ps
module twc_bus_model (
	// design drive and bench acknowledge enable
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic ack_en,
	// resolved wires
	output logic       scl_line,
	output logic       sda_line,
	// observed traffic
	output logic [7:0] rx_byte,
	output logic [7:0] n_start,
	output logic [7:0] n_stop
);
	logic       m_scl = 1'b0;
	logic       m_sda = 1'b0;
	logic       own   = 1'b0;
	logic [7:0] shr   = 8'h00;
	int         nbit  = 0;
	// pull-ups: a released line reads high
	assign scl_line = !(scl_oe || m_scl);
	assign sda_line = !(sda_oe || m_sda);
	initial begin
		rx_byte = 8'h00;
		n_start = 8'h00;
		n_stop  = 8'h00;
	end
	always @(negedge sda_line) if (scl_line) begin
		nbit = 0;
		n_start = n_start + 8'h01;
	end
	always @(posedge sda_line) if (scl_line) n_stop = n_stop + 8'h01;
	always @(posedge scl_line) begin
		if (nbit < 8) shr = {shr[6:0], sda_line}; // msb first
		nbit = nbit + 1;
	end
	// ack lags the falling clock so it never looks like a start
	always @(negedge scl_line) if (!own) begin
		if (nbit == 8 && ack_en) m_sda <= #20 1'b1;
		if (nbit == 9) begin
			m_sda <= #20 1'b0;
			rx_byte = shr;
			nbit = 0;
		end
	end
	task automatic put_byte(input logic [7:0] b, output logic ack);
		#80;
		for (int i = 7; i >= 0; i--) begin
			#40 m_sda = !b[i];
			#40 m_scl = 1'b0;
			#80 m_scl = 1'b1;
		end
		#40 m_sda = 1'b0;
		#40 m_scl = 1'b0;
		#40 ack = sda_line;
		#40 m_scl = 1'b1;
	endtask : put_byte
	task automatic frame(input logic [6:0] a, input logic [7:0] d, output logic ack_a, output logic ack_d);
		own = 1'b1;
		m_sda = 1'b1;
		#80 m_scl = 1'b1;
		put_byte({a, 1'b0}, ack_a); // short address, write
		put_byte(d, ack_d);
		#40 m_sda = 1'b1;
		#40 m_scl = 1'b0;
		#80 m_sda = 1'b0;
		#160 own = 1'b0;
	endtask : frame
	task automatic grab();
		own = 1'b1;
		m_sda = 1'b1;
		#80 m_scl = 1'b1;
	endtask : grab
	task automatic free();
		#80 m_scl = 1'b0;
		#80 m_sda = 1'b0;
		#160 own = 1'b0;
	endtask : free
	// read frame: long low phase leaves room for the slave's filter delay
	task automatic get_frame(input logic [6:0] a, output logic [7:0] d, output logic ack_a);
		own = 1'b1;
		m_sda = 1'b1;
		#80 m_scl = 1'b1;
		put_byte({a, 1'b1}, ack_a); // read direction
		for (int i = 7; i >= 0; i--) begin
			#100 m_scl = 1'b0;
			#40 d[i] = sda_line;
			#20 m_scl = 1'b1;
		end
		#100 m_scl = 1'b0; // line left released: not-acknowledge
		#60 m_scl = 1'b1;
		#40 m_sda = 1'b1;
		free();
	endtask : get_frame
endmodule : twc_bus_model

// file: tb/twc_props.sv
// port checker of the two-wire controller
`timescale 1ns/100ps
module twc_props
	import twc_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// register bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// system
	input wire logic        irq,
	input wire logic        wake,
	// bus lines
	input wire logic        scl_line,
	input wire logic        scl_val,
	input wire logic        scl_oe,
	input wire logic        sda_line,
	input wire logic        sda_val,
	input wire logic        sda_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic rd_ok;
	logic wr_ok;
	assign rd_ok = avs_read && !avs_waitrequest;
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	////////////////////////////////////////////////////////////////////////
	property p_wait_first;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("access not answered in second cycle");
	property p_wait_once;
		(avs_read || avs_write) && !avs_waitrequest |-> $past(avs_waitrequest);
	endproperty
	a_wait_once: assert property (p_wait_once) else $error("access answered without wait state");
	property p_vals;
		!scl_val && !sda_val;
	endproperty
	a_vals: assert property (p_vals) else $error("open drain line driven high");
	property p_mask_off;
		wr_ok && avs_address == OFF_MASK && avs_writedata[EV_W-1:0] == 6'h00 |=> !irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq high with all events masked");
	property p_wake_clr;
		wr_ok && avs_address == OFF_CTRL && !avs_writedata[CTRL_SLEEP] |-> ##[1:2] !wake;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake kept after sleep cleared");
	property p_unmapped;
		rd_ok && avs_address > OFF_MASK |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_narrow;
		rd_ok && (avs_address == OFF_TX || avs_address == OFF_RX) |-> avs_readdata[31:8] == 24'h0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("byte register upper bits set");
	property p_div;
		rd_ok && avs_address == OFF_DIV |-> avs_readdata[15:0] >= DIV_MIN && avs_readdata[31:16] == 16'h0;
	endproperty
	a_div: assert property (p_div) else $error("divider below fastest rate");
	property p_reset_idle;
		$fell(rst) |-> !scl_oe && !sda_oe && !irq && !wake;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
	c_start: cover property ($rose(sda_oe) && scl_line);
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wake));
endmodule : twc_props

bind twc_top twc_props i_twc_props (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .wake, .scl_line, .scl_val, .scl_oe, .sda_line,
	.sda_val, .sda_oe);

// file: tb/twc_top_tb.sv
// self-checking bench of the two-wire controller
`timescale 1ns/100ps
module twc_top_tb;
	import twc_pkg::*;
	logic        sys_clk, rst, avs_read, avs_write, ack_en, a0, a1;
	logic [5:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic        avs_waitrequest, irq, wake, scl_line, scl_val, scl_oe, sda_line, sda_val, sda_oe;
	logic [7:0]  rx_byte, n_start, n_stop, s0;
	int          n_errors   = 0;
	int          num_checks = 0;
	twc_top i_twc_top (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .irq, .wake, .scl_line, .scl_val, .scl_oe, .sda_line, .sda_val, .sda_oe);
	twc_bus_model i_twc_bus_model (.scl_oe, .sda_oe, .ack_en, .scl_line, .sda_line, .rx_byte, .n_start, .n_stop);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// one bus access, held until waitrequest is seen low
	task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50) chk(32'h1, 32'h0);
	endtask : acc
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask : rdc
	task automatic rdb(input logic [5:0] a, input int b, input logic e);
		acc(1'b0, a, 32'h0);
		chk(32'(rdv[b]), 32'(e));
	endtask : rdb
	task automatic wait_ev(input int b);
		int n;
		n = 0;
		do begin
			acc(1'b0, OFF_IRQ, 32'h0);
			n++;
		end while (rdv[b] !== 1'b1 && n < 1000);
		chk(32'(rdv[b]), 32'h1);
	endtask : wait_ev
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdc(OFF_CTRL, 32'h0);
		rdc(OFF_DIV, {16'h0, DIV_RST});
		rdc(OFF_TX, {24'h0, TX_RST});
		rdc(6'h24, 32'h0);
		wr(OFF_DIV, 32'h0000000a);
		rdc(OFF_DIV, {16'h0, DIV_MIN});
	endtask : t_regs
	task automatic t_slave();
		wr(OFF_ADDR, 32'h2a);
		wr(OFF_MASK, 32'h3f);
		wr(OFF_CTRL, 32'h1);
		i_twc_bus_model.frame(7'h2a, 8'h5c, a0, a1);
		chk(a0, 1'b0);
		chk(a1, 1'b0);
		rdc(OFF_RX, 32'h5c);
		rdb(OFF_IRQ, EV_START, 1'b1);
		rdb(OFF_IRQ, EV_ADDR, 1'b1);
		rdb(OFF_IRQ, EV_STOP, 1'b1);
		@(negedge sys_clk);
		chk(irq, 1'b1);
		wr(OFF_MASK, 32'h0);
		@(negedge sys_clk);
		chk(irq, 1'b0);
		wr(OFF_IRQ, 32'h3f);
		rdc(OFF_IRQ, 32'h0);
		wr(OFF_MASK, 32'h3f);
		i_twc_bus_model.frame(7'h15, 8'h33, a0, a1);
		chk(a0, 1'b1);
		rdb(OFF_IRQ, EV_ADDR, 1'b0);
		wr(OFF_TX, 32'hc6);
		i_twc_bus_model.get_frame(7'h2a, s0, a0);
		chk(32'(a0), 32'h0);
		chk(32'(s0), 32'hc6);
		rdb(OFF_STAT, 3, 1'b1);
		wr(OFF_IRQ, 32'h3f);
	endtask : t_slave
	task automatic t_mst_only();
		wr(OFF_CTRL, 32'h2);
		i_twc_bus_model.frame(7'h2a, 8'h11, a0, a1);
		rdb(OFF_IRQ, EV_START, 1'b0);
		wr(OFF_IRQ, 32'h3f);
	endtask : t_mst_only
	task automatic t_master();
		s0 = n_start;
		wr(OFF_TX, 32'h54);
		wr(OFF_CMD, 32'h01);
		repeat (300) @(posedge sys_clk);
		chk(n_start, s0 + 8'h01);
		wr(OFF_CMD, 32'h04);
		wait_ev(EV_BYTE);
		chk(rx_byte, 8'h54);
		rdb(OFF_STAT, 4, 1'b0);
		wr(OFF_IRQ, 32'h3f);
		wr(OFF_TX, 32'h3c);
		wr(OFF_CMD, 32'h01);
		repeat (400) @(posedge sys_clk);
		chk(n_start, s0 + 8'h02);
		wr(OFF_CMD, 32'h04);
		wait_ev(EV_BYTE);
		chk(rx_byte, 8'h3c);
		wr(OFF_IRQ, 32'h3f);
		ack_en <= 1'b0;
		wr(OFF_TX, 32'ha5);
		wr(OFF_CMD, 32'h04);
		wait_ev(EV_NACK);
		rdb(OFF_STAT, 4, 1'b1);
		wr(OFF_IRQ, 32'h3f);
		wr(OFF_CMD, 32'h08);
		wait_ev(EV_BYTE);
		rdc(OFF_RX, 32'hff);
		rdb(OFF_STAT, 4, 1'b0);
		ack_en <= 1'b1;
		s0 = n_stop;
		wr(OFF_CMD, 32'h02);
		repeat (400) @(posedge sys_clk);
		chk(n_stop, s0 + 8'h01);
		wr(OFF_IRQ, 32'h3f);
	endtask : t_master
	task automatic t_arb();
		wr(OFF_CTRL, 32'h3);
		i_twc_bus_model.grab();
		wr(OFF_CMD, 32'h01);
		wait_ev(EV_ARB);
		i_twc_bus_model.free();
		wr(OFF_IRQ, 32'h3f);
	endtask : t_arb
	task automatic t_wake();
		wr(OFF_CTRL, 32'hd);
		i_twc_bus_model.frame(7'h2a, 8'h22, a0, a1);
		chk(a0, 1'b0);
		@(negedge sys_clk);
		chk(wake, 1'b1);
		wr(OFF_CTRL, 32'h1);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(wake, 1'b0);
	endtask : t_wake
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#500000;
		n_errors++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		ack_en = 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_slave();
		t_mst_only();
		t_master();
		t_arb();
		t_wake();
		close_out();
	end
endmodule : twc_top_tb
